// ==== shared/cam_pkg.sv ====
// constants for the counter array module mode control block
package cam_pkg;

	// apb register byte offsets
	localparam logic [11:0] OFS_MODE   = 12'h000;
	localparam logic [11:0] OFS_CAPCMP = 12'h004;
	localparam logic [11:0] OFS_COUNT  = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00c;
	localparam logic [11:0] OFS_MASK   = 12'h010;

	// field positions of module_mode_register
	localparam int unsigned MODE_IRQ_EN = 0;
	localparam int unsigned MODE_PWM    = 1;
	localparam int unsigned MODE_TOG    = 2;
	localparam int unsigned MODE_MAT    = 3;
	localparam int unsigned MODE_FALL   = 4;
	localparam int unsigned MODE_RISE   = 5;
	localparam int unsigned MODE_CMP    = 6;
	localparam int unsigned MODE_RSVD   = 7;

	// implemented bits of the mode register, bit 7 excluded
	localparam logic [7:0] MODE_IMPL_MASK = 8'h7f;
	localparam logic [7:0] MODE_RST       = 8'h00;

	// status and mask layout
	localparam int unsigned ST_W       = 3;
	localparam int unsigned ST_EVENT   = 0;
	localparam int unsigned ST_MATCH   = 1;
	localparam int unsigned ST_CAPTURE = 2;
	localparam logic [2:0]  STATUS_RST = 3'h0;
	localparam logic [2:0]  MASK_RST   = 3'h1;

	// compare/capture register
	localparam int unsigned CNT_W      = 16;
	localparam int unsigned PWM_W      = 8;
	localparam logic [15:0] CAPCMP_RST = 16'h0000;

	// pin path reset level
	localparam logic PIN_RST = 1'b0;

	// apb response sequencer
	typedef enum logic [0:0] {
		CAM_APB_IDLE,
		CAM_APB_RESP
	} cam_apb_e;

endpackage

// ==== rtl/cam_pin_sync.sv ====
// two-stage synchroniser and edge detector for the module pin input
module cam_pin_sync (
	input  wire logic i_sys_clk,
	input  wire logic i_resetn,
	input  wire logic i_clk_en,
	input  wire logic i_pin,
	output logic      o_level,
	output logic      o_rise,
	output logic      o_fall
);

	logic meta_r;
	logic sync_r;
	logic prev_r;

	// meta_r feeds only sync_r; edges compare sync_r with prev_r
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			meta_r <= cam_pkg::PIN_RST;
			sync_r <= cam_pkg::PIN_RST;
			prev_r <= cam_pkg::PIN_RST;
		end else if (i_clk_en) begin
			meta_r <= i_pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// edge pulses, one cycle each
	assign o_level = sync_r;
	assign o_rise  = sync_r & ~prev_r;
	assign o_fall  = ~sync_r & prev_r;

endmodule

// ==== rtl/cam_top.sv ====
// compare/capture module with mode register, apb slave and interrupt
// Notes on behaviour
// - mode bit 7 is reserved, reads zero and changes nothing.
// - comparator_enable turns on counter versus compare/capture register comparison.
// - rise_capture_enable makes a rising pin edge a capture event.
// - fall_capture_enable makes a falling edge capture; both bits capture either edge.
// - match_flag_enable sets module_event_flag on a counter match, raising a request.
// - match_toggle_enable inverts the pin level on each counter match while pulse_width_output_enable is clear.
// - pulse_width_output_enable drives the pin as a pulse width output.
// - module_irq_enable lets a set module_event_flag raise the interrupt.
//
// Implementation choices: the APB register port and the register addresses.
module cam_top (
	input  wire logic        i_sys_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_clk_en,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// shared counter value, same clock domain
	input  wire logic [15:0] i_count_value,
	// module_io_pin as three signals
	input  wire logic        i_module_io_pin_in,
	output logic             o_module_io_pin_out,
	output logic             o_module_io_pin_oe,
	// level interrupt
	output logic             o_irq
);

	// bus side registers
	cam_pkg::cam_apb_e apb_st_r;
	cam_pkg::cam_apb_e apb_st_nxt;
	logic [31:0]       prdata_r;
	logic [31:0]       prdata_nxt;
	logic              pready_r;
	logic              pready_nxt;
	logic              pslverr_r;
	logic              pslverr_nxt;

	// configuration and status registers
	logic [7:0]        mode_r;
	logic [7:0]        mode_nxt;
	logic [15:0]       capcmp_r;
	logic [15:0]       capcmp_nxt;
	logic [2:0]        status_r;
	logic [2:0]        status_nxt;
	logic [2:0]        mask_r;
	logic [2:0]        mask_nxt;

	// comparator history, pin drive and interrupt registers
	logic              eq_prev_r;
	logic              toggle_r;
	logic              toggle_nxt;
	logic              pin_out_r;
	logic              pin_out_nxt;
	logic              pin_oe_r;
	logic              pin_oe_nxt;
	logic              irq_r;
	logic              irq_nxt;

	// synchronised pin edges; the level itself is not needed here
	wire pin_rise;
	wire pin_fall;

	// pin passes two flops before any edge is formed
	cam_pin_sync u_pin_sync (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_clk_en  (i_clk_en),
		.i_pin     (i_module_io_pin_in),
		.o_level   (),
		.o_rise    (pin_rise),
		.o_fall    (pin_fall)
	);

	// apb phase qualifiers
	wire apb_access = i_psel & i_penable;
	wire apb_start  = apb_access & (apb_st_r == cam_pkg::CAM_APB_IDLE);
	wire apb_done   = apb_access & (apb_st_r == cam_pkg::CAM_APB_RESP);
	wire wr_done    = apb_done & i_pwrite;
	wire rd_done    = apb_done & ~i_pwrite;

	// address decode
	wire sel_mode   = (i_paddr == cam_pkg::OFS_MODE);
	wire sel_capcmp = (i_paddr == cam_pkg::OFS_CAPCMP);
	wire sel_count  = (i_paddr == cam_pkg::OFS_COUNT);
	wire sel_status = (i_paddr == cam_pkg::OFS_STATUS);
	wire sel_mask   = (i_paddr == cam_pkg::OFS_MASK);
	wire sel_none   = ~(sel_mode | sel_capcmp | sel_count | sel_status | sel_mask);

	// write strobes per register and the status read strobe
	wire wr_mode    = wr_done & sel_mode & i_pstrb[0];
	wire wr_cap_lo  = wr_done & sel_capcmp & i_pstrb[0];
	wire wr_cap_hi  = wr_done & sel_capcmp & i_pstrb[1];
	wire wr_mask    = wr_done & sel_mask & i_pstrb[0];
	wire rd_status  = rd_done & sel_status;

	// mode field views
	wire cmp_en   = mode_r[cam_pkg::MODE_CMP];
	wire rise_en  = mode_r[cam_pkg::MODE_RISE];
	wire fall_en  = mode_r[cam_pkg::MODE_FALL];
	wire mat_en   = mode_r[cam_pkg::MODE_MAT];
	wire tog_en   = mode_r[cam_pkg::MODE_TOG];
	wire pwm_en   = mode_r[cam_pkg::MODE_PWM];
	wire irq_en   = mode_r[cam_pkg::MODE_IRQ_EN];

	// comparator: one match event when equality begins
	wire cnt_eq    = (i_count_value == capcmp_r);
	wire match_evt = cmp_en & cnt_eq & ~eq_prev_r;

	// capture on the enabled pin edges
	wire cap_rise = rise_en & pin_rise;
	wire cap_fall = fall_en & pin_fall;
	wire cap_evt  = cap_rise | cap_fall;

	// flag sources
	wire match_flag = match_evt & mat_en;
	wire [2:0] st_set = {cap_evt, match_flag, cap_evt | match_flag};
	wire [2:0] st_clr = rd_status ? {cam_pkg::ST_W{1'b1}} : 3'h0;

	// pulse width level from low counter byte against low register byte
	wire pwm_level = (i_count_value[cam_pkg::PWM_W-1:0] >= capcmp_r[cam_pkg::PWM_W-1:0]);

	// read data selection, reserved and unused bits read zero
	wire [31:0] rd_mux =
		sel_mode   ? {24'h000000, mode_r & cam_pkg::MODE_IMPL_MASK} :
		sel_capcmp ? {16'h0000, capcmp_r} :
		sel_count  ? {16'h0000, i_count_value} :
		sel_status ? {29'h00000000, status_r} :
		sel_mask   ? {29'h00000000, mask_r} :
		32'h00000000;

	// apb response sequencer, one wait state per access
	always_comb begin
		apb_st_nxt  = apb_st_r;
		pready_nxt  = 1'b0;
		prdata_nxt  = prdata_r;
		pslverr_nxt = 1'b0;
		case (apb_st_r)
			cam_pkg::CAM_APB_IDLE: begin
				if (apb_start) begin
					apb_st_nxt  = cam_pkg::CAM_APB_RESP;
					pready_nxt  = 1'b1;
					pslverr_nxt = sel_none;
					prdata_nxt  = i_pwrite ? 32'h00000000 : rd_mux;
				end
			end
			cam_pkg::CAM_APB_RESP: begin
				apb_st_nxt = cam_pkg::CAM_APB_IDLE;
			end
			default: begin
				apb_st_nxt = cam_pkg::CAM_APB_IDLE;
			end
		endcase
	end

	// mode register, reserved bit never stored
	assign mode_nxt = wr_mode ? (i_pwdata[7:0] & cam_pkg::MODE_IMPL_MASK) : mode_r;

	// compare/capture register, capture beats a software write
	always_comb begin
		capcmp_nxt = capcmp_r;
		if (wr_cap_lo) begin
			capcmp_nxt[7:0] = i_pwdata[7:0];
		end
		if (wr_cap_hi) begin
			capcmp_nxt[15:8] = i_pwdata[15:8];
		end
		if (cap_evt) begin
			capcmp_nxt = i_count_value;
		end
	end

	// sticky status, read clears, new event wins over the clear
	for (genvar b = 0; b < cam_pkg::ST_W; b++) begin : g_status
		assign status_nxt[b] = st_set[b] | (status_r[b] & ~st_clr[b]);
	end
	assign mask_nxt   = wr_mask ? i_pwdata[cam_pkg::ST_W-1:0] : mask_r;

	// interrupt only while the module irq enable is set
	assign irq_nxt = irq_en & (|(status_nxt & mask_nxt));

	// pin drive: pulse width mode first, else toggle state
	assign toggle_nxt  = toggle_r ^ (match_evt & tog_en);
	assign pin_out_nxt = pwm_en ? pwm_level : toggle_nxt;
	assign pin_oe_nxt  = pwm_en | tog_en;

	// bus sequencer and response flops
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			apb_st_r  <= cam_pkg::CAM_APB_IDLE;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (i_clk_en) begin
			apb_st_r  <= apb_st_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// read data flop
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			prdata_r <= 32'h00000000;
		end else if (i_clk_en) begin
			prdata_r <= prdata_nxt;
		end
	end

	// mode register
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			mode_r <= cam_pkg::MODE_RST;
		end else if (i_clk_en) begin
			mode_r <= mode_nxt;
		end
	end

	// compare/capture register
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			capcmp_r <= cam_pkg::CAPCMP_RST;
		end else if (i_clk_en) begin
			capcmp_r <= capcmp_nxt;
		end
	end

	// sticky status register
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			status_r <= cam_pkg::STATUS_RST;
		end else if (i_clk_en) begin
			status_r <= status_nxt;
		end
	end

	// interrupt mask register
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			mask_r <= cam_pkg::MASK_RST;
		end else if (i_clk_en) begin
			mask_r <= mask_nxt;
		end
	end

	// level interrupt flop
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			irq_r <= 1'b0;
		end else if (i_clk_en) begin
			irq_r <= irq_nxt;
		end
	end

	// comparator history, so a stalled counter matches once
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			eq_prev_r <= 1'b0;
		end else if (i_clk_en) begin
			eq_prev_r <= cnt_eq;
		end
	end

	// toggle state, kept while toggling is disabled
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			toggle_r <= cam_pkg::PIN_RST;
		end else if (i_clk_en) begin
			toggle_r <= toggle_nxt;
		end
	end

	// pin level flop
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			pin_out_r <= cam_pkg::PIN_RST;
		end else if (i_clk_en) begin
			pin_out_r <= pin_out_nxt;
		end
	end

	// pin output enable flop
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			pin_oe_r <= 1'b0;
		end else if (i_clk_en) begin
			pin_oe_r <= pin_oe_nxt;
		end
	end

	// outputs straight from flops
	assign o_prdata            = prdata_r;
	assign o_pready            = pready_r;
	assign o_pslverr           = pslverr_r;
	assign o_module_io_pin_out = pin_out_r;
	assign o_module_io_pin_oe  = pin_oe_r;
	assign o_irq               = irq_r;

endmodule

// ==== tb/cam_properties.sv ====
// port checker for the mode control block
module cam_props (
	input wire logic        i_sys_clk,
	input wire logic        i_resetn,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0]  i_pstrb,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        o_module_io_pin_out,
	input wire logic        o_module_io_pin_oe,
	input wire logic        o_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	logic [6:0] mode_r;
	wire wr = i_psel & i_penable & o_pready & i_pwrite;
	wire rd0 = o_pready & !i_pwrite & i_paddr == 12'h000;
	wire drv = |mode_r[2:1];
	// shadow of the mode register, written when the access completes
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) mode_r <= 7'h00;
		else if (wr && i_paddr == 12'h000 && i_pstrb[0]) mode_r <= i_pwdata[6:0];
	end
	a_ready_wait: assert property (i_psel && i_penable && !$past(i_penable) |=> o_pready)
		else $error("no ready after one wait");
	a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready too long");
	a_err_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
	a_err_map: assert property (o_pready |-> o_pslverr ==
		!(i_paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010}))
		else $error("error flag wrong");
	a_rsvd_zero: assert property (rd0 |-> o_prdata[31:7] == 25'h0)
		else $error("reserved bit set");
	a_mode_read: assert property (rd0 |-> o_prdata[6:0] == mode_r)
		else $error("mode readback");
	a_irq_gate: assert property (!mode_r[0] && !$past(mode_r[0]) |-> !o_irq)
		else $error("irq while disabled");
	a_oe_mode: assert property ($stable(drv) |-> o_module_io_pin_oe == drv)
		else $error("pin enable wrong");
	a_pin_hold: assert property ((!drv) [*3] |-> $stable(o_module_io_pin_out))
		else $error("pin moved undriven");
	cover property (wr);
	cover property ($rose(o_irq));
	cover property (o_pslverr);
endmodule

// ==== tb/cam_pin_model.sv ====
// far-side model of the module pin
module cam_pin_model (
	input  wire logic i_sys_clk,
	input  wire logic i_level,
	input  wire logic i_blk_out,
	input  wire logic i_blk_oe,
	output logic      o_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ext_r = 1'b0;
	// external source changes just after an edge
	always_ff @(posedge i_sys_clk) ext_r <= i_level;
	// wire level from the block's enable: block output while it is set, else the external source
	assign o_pin = i_blk_oe ? i_blk_out : ext_r;
endmodule

// ==== tb/cam_tb_top.sv ====
// self-checking bench for the mode control block
module cam_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic w; logic [11:0] a; logic [31:0] d, x; logic err;} cam_row_s;
	logic        clk, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, lvl = 1'b0, ce = 1'b1;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0, q, prd;
	logic [15:0] cnt = 16'h0055, ec, xc = 16'habcd;
	logic        e, prdy, perr, pout, poe, irq, pin, cap, hit, p;
	logic [7:0]  cm [4] = '{8'h21, 8'h11, 8'h31, 8'h20};
	logic [7:0]  mm [3] = '{8'h4d, 8'h0d, 8'h45};
	int          n_fail = 0;
	int          comparisons = 0;
	cam_row_s    rows [8] = '{'{1'b0, 12'h000, 32'h0, 32'h0, 1'b0},
		'{1'b0, 12'h010, 32'h0, 32'h1, 1'b0}, '{1'b1, 12'h000, 32'h80, 32'h0, 1'b0},
		'{1'b1, 12'h004, 32'h1234abcd, 32'habcd, 1'b0}, '{1'b1, 12'h010, 32'hff, 32'h7, 1'b0},
		'{1'b1, 12'h008, 32'h0, 32'h55, 1'b0}, '{1'b1, 12'h00c, 32'h7, 32'h0, 1'b0},
		'{1'b1, 12'h014, 32'h5, 32'h0, 1'b1}};
	cam_top dut (.i_sys_clk(clk), .i_resetn(rstn), .i_clk_en(ce), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .i_pstrb(4'hf),
		.o_prdata(prd), .o_pready(prdy), .o_pslverr(perr), .i_count_value(cnt),
		.i_module_io_pin_in(pin), .o_module_io_pin_out(pout), .o_module_io_pin_oe(poe),
		.o_irq(irq));
	cam_pin_model u_pin (.i_sys_clk(clk), .i_level(lvl), .i_blk_out(pout), .i_blk_oe(poe),
		.o_pin(pin));
	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, x);
		comparisons++;
		if (g !== x) begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, g, x);
		end
	endtask
	// one apb transfer, held until ready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1 && n < 20);
		q = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n >= 20) begin
			n_fail++;
			conclude();
		end else begin
			@(posedge clk);
		end
	endtask
	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0);
			chk(q, rows[i].x);
			chk({31'h0, e}, {31'h0, rows[i].err});
		end
		// capture on each edge kind, with and without irq enable
		foreach (cm[i]) begin
			apb(1'b1, 12'h000, {24'h0, cm[i]});
			for (int k = 0; k < 2; k++) begin
				ec = cnt + 16'h0011;
				cnt <= ec;
				lvl <= ~lvl;
				cap = k ? cm[i][4] : cm[i][5];
				if (cap) xc = ec;
				repeat (6) @(posedge clk);
				chk({31'h0, irq}, {31'h0, cap & cm[i][0]});
				apb(1'b0, 12'h00c, 32'h0);
				chk(q, {29'h0, cap, 1'b0, cap});
				apb(1'b0, 12'h004, 32'h0);
				chk(q, {16'h0, xc});
				repeat (3) @(posedge clk);
				chk({31'h0, irq}, 32'h0);
			end
		end
		// counter match with flag and toggle combinations
		apb(1'b1, 12'h004, 32'h40);
		foreach (mm[i]) begin
			cnt <= 16'h003f;
			apb(1'b1, 12'h000, {24'h0, mm[i]});
			p = pout;
			cnt <= 16'h0040;
			repeat (4) @(posedge clk);
			hit = mm[i][6];
			chk({31'h0, pout}, {31'h0, p ^ (hit & mm[i][2])});
			chk({31'h0, irq}, {31'h0, hit & mm[i][3]});
			apb(1'b0, 12'h00c, 32'h0);
			chk(q, {30'h0, {2{hit & mm[i][3]}}});
		end
		// pulse width output against the low byte
		apb(1'b1, 12'h000, 32'h2);
		for (int k = 0; k < 2; k++) begin
			cnt <= 16'h013f + 16'(k);
			repeat (4) @(posedge clk);
			chk({30'h0, poe, pout}, {30'h0, 1'b1, k[0]});
		end
		// clock enable low freezes the pin drive, which follows again once raised
		ce <= 1'b0;
		cnt <= 16'h013f;
		repeat (4) @(posedge clk);
		chk({31'h0, pout}, 32'h1);
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		chk({31'h0, pout}, 32'h0);
		// mid-run reset returns the ready, pin and irq outputs and the mode and mask registers to their reset values
		cnt <= 16'h0140;
		repeat (2) @(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		chk({28'h0, prdy, poe, pout, irq}, 32'h0);
		rstn <= 1'b1;
		@(posedge clk);
		apb(1'b0, 12'h000, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk(q, 32'h1);
		conclude();
	end
endmodule
bind cam_top cam_props u_props (.*);
